// [hw/sue_dup_det.sv]
`timescale 1ns/1ps

// marks each unit number claimed by two or more slots
module sue_dup_det
  import sue_pkg::*;
#(
  parameter int N_SLOTS = 16
) (
  input  wire logic                       [N_SLOTS-1:0] present,  // slot occupied
  input  wire sue_pkg::sue_unit_no_t      [N_SLOTS-1:0] unit_no,  // switch setting
  output logic                            [15:0]        dup_mask, // duplicated numbers
  output logic                            [15:0]        used_mask // numbers in use
);

  always_comb begin
    dup_mask  = '0;
    used_mask = '0;
    for (int s = 0; s < N_SLOTS; s++) begin
      if (present[s]) begin
        if (used_mask[unit_no[s]]) begin
          dup_mask[unit_no[s]] = 1'b1;
        end
        used_mask[unit_no[s]] = 1'b1;
      end
    end
  end
endmodule

// [hw/sue_params.svh]
`ifndef SUE_PARAMS_SVH
`define SUE_PARAMS_SVH

// ****************************************************************
// register word offsets
// ****************************************************************
`define SUE_OFS_STATUS      4'h0
`define SUE_OFS_FLAGS_PRI   4'h1
`define SUE_OFS_FLAGS_EXT   4'h2
`define SUE_OFS_RESTART_PRI 4'h3
`define SUE_OFS_RESTART_EXT 4'h4
`define SUE_OFS_IRQ_STAT    4'h5
`define SUE_OFS_IRQ_MASK    4'h6
`define SUE_OFS_DUP_MASK    4'h7

// ****************************************************************
// field positions
// ****************************************************************
`define SUE_STAT_HALT_BIT    0
`define SUE_STAT_SUMMARY_BIT 1
`define SUE_STAT_EXT_EN_BIT  2
`define SUE_IRQ_DUP_BIT      0
`define SUE_IRQ_REFRESH_BIT  1
`define SUE_IRQ_RESTART_BIT  2

// ****************************************************************
// reset values and counts
// ****************************************************************
`define SUE_RST_WORD         16'h0000
`define SUE_RST_IRQ_MASK     3'h0
`define SUE_PRI_UNITS        10
`define SUE_ALL_UNITS        16
`define SUE_WORDS_PER_UNIT   10
`define SUE_PRI_BASE         100
`define SUE_EXT_BASE         400
`define SUE_REFRESH_DIV      20

`endif

// [hw/sue_pkg.sv]
package sue_pkg;

  typedef logic [3:0]  sue_unit_no_t;
  typedef logic [15:0] sue_word_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } sue_bus_req_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  unit;
    logic [9:0]  word_addr;
  } sue_refresh_t;

  typedef enum logic [1:0] {
    ST_POWER_UP,
    ST_SCAN,
    ST_HALTED
  } sue_state_t;

endpackage

// [hw/sue_supervisor.sv]
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "sue_params.svh"

// Overview of operation
// RULE_01: duplicated unit number sets summary bit and halts the user program.
// RULE_02: per-unit error flags show which unit number is duplicated.
// RULE_03: refresh error sets summary bit, stops only that unit, program runs.
// RULE_04: one error flag per unit 0..9, set on duplicate or refresh error.
// RULE_05: sixteen-unit variant mirrors the flags for units 0..15 in a second range.
// RULE_06: restart bit per unit 0..9; off-on-off toggle restarts that unit.
// RULE_07: software toggles restart after config changes or clearing an error.
// RULE_08: power-up restarts every unit as a restart toggle would.
// RULE_09: sixteen-unit variant accepts restart toggles for units 0..15 too.
// RULE_10: completed restart clears the unit flag; recurring error sets it again.
// RULE_11: each unit owns ten refresh words from 100 plus ten times its number; units 10..15 use 400 plus ten times (number minus 10) instead.
module sue_supervisor
  import sue_pkg::*;
#(
  parameter int N_SLOTS     = 16,
  parameter bit EXT_EN      = 1'b1,
  parameter int REFRESH_DIV = `SUE_REFRESH_DIV
) (
  input  wire logic                              clk_sys,        // 20 MHz system clock
  input  wire logic                              reset,          // async reset, high
  input  wire sue_pkg::sue_bus_req_t             bus_req,        // register request
  output logic                         [15:0]    bus_rdata,      // read data, next cycle
  input  wire logic                    [N_SLOTS-1:0] slot_present, // slot occupied
  input  wire sue_pkg::sue_unit_no_t   [N_SLOTS-1:0] slot_unit_no, // unit number switch
  input  wire logic                    [15:0]    refresh_err,    // refresh error per unit
  input  wire logic                    [15:0]    restart_done,   // unit finished restart
  output logic                         [15:0]    unit_restart,   // restart pulse per unit
  output logic                         [15:0]    unit_stop,      // unit held stopped
  output logic                                   program_halt,   // user program stopped
  output logic                                   special_unit_error_summary_bit, // summary
  output sue_pkg::sue_refresh_t                  refresh,        // refresh word slot
  output logic                                   irq             // level interrupt
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [9:0] unit_base(input logic [3:0] n);
    logic [9:0] b;
    if (n < 4'(`SUE_PRI_UNITS)) begin
      b = 10'(`SUE_PRI_BASE) + 10'(n) * 10'(`SUE_WORDS_PER_UNIT); // RULE_11
    end else begin
      b = 10'(`SUE_EXT_BASE) + 10'(n - 4'(`SUE_PRI_UNITS)) * 10'(`SUE_WORDS_PER_UNIT);
    end
    return b;
  endfunction

  function automatic logic [15:0] unit_range(input logic ext);
    return ext ? 16'hFFFF : 16'h03FF;
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [15:0]  range_mask;
  logic [15:0]  dup_mask;
  logic [15:0]  used_mask;
  logic [15:0]  flags_ff;
  logic [15:0]  dup_seen_ff;
  logic [15:0]  stop_ff;
  logic [15:0]  busy_ff;
  logic [15:0]  restart_pri_ff;
  logic [15:0]  restart_ext_ff;
  logic [15:0]  restart_level;
  logic [15:0]  toggle_pulse;
  logic [15:0]  restart_fire;
  logic [15:0]  err_set;
  logic [15:0]  done_clr;
  logic [15:0]  rdata_ff;
  logic [15:0]  nxt_rdata;
  logic [2:0]   irq_stat_ff;
  logic [2:0]   irq_mask_ff;
  logic [2:0]   irq_event;
  logic         halt_ff;
  logic         por_fire;
  logic         tick;
  logic [7:0]   div_ff;
  logic [3:0]   scan_unit_ff;
  logic [3:0]   scan_word_ff;
  sue_refresh_t refresh_ff;
  sue_state_t   state_ff;
  sue_state_t   nxt_state;
  logic         rd_stat;

  assign range_mask = unit_range(EXT_EN);

  // ****************************************************************
  // duplicate detection
  // ****************************************************************
  sue_dup_det #(
    .N_SLOTS (N_SLOTS)
  ) u_dup (
    .present   (slot_present),
    .unit_no   (slot_unit_no),
    .dup_mask  (dup_mask),
    .used_mask (used_mask)
  );

  // a duplicate stops everything until power is cycled
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      halt_ff <= 1'b0;
    end else if (|dup_mask) begin
      halt_ff <= 1'b1; // RULE_01
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dup_seen_ff <= '0;
    end else begin
      dup_seen_ff <= dup_seen_ff | dup_mask; // RULE_02
    end
  end

  // ****************************************************************
  // state machine
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POWER_UP: begin
        nxt_state = ST_SCAN;
      end
      ST_SCAN: begin
        if (|dup_mask) begin
          nxt_state = ST_HALTED;
        end
      end
      ST_HALTED: begin
        nxt_state = ST_HALTED;
      end
      default: begin
        nxt_state = ST_HALTED;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_ff <= ST_POWER_UP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // power-up restarts all units once, as a toggle of every bit would
  assign por_fire = (state_ff == ST_POWER_UP); // RULE_08

  // ****************************************************************
  // restart bits
  // ****************************************************************
  // with EXT_EN both ranges are ored; toggling either one restarts the unit while the other range's bit stays off
  assign restart_level = (restart_pri_ff & 16'h03FF)
                       | (EXT_EN ? restart_ext_ff : 16'h0000); // RULE_09

  sue_toggle_det #(
    .W (16)
  ) u_toggle (
    .clk_sys (clk_sys),
    .reset   (reset),
    .level   (restart_level),
    .pulse   (toggle_pulse)
  );

  assign restart_fire = ((por_fire ? 16'hFFFF : 16'h0000) | toggle_pulse) & range_mask;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      unit_restart <= '0;
    end else begin
      unit_restart <= restart_fire; // RULE_06
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy_ff <= '0;
    end else begin
      busy_ff <= (busy_ff & ~restart_done) | restart_fire;
    end
  end

  assign done_clr = busy_ff & restart_done;

  // ****************************************************************
  // error flags and unit stop
  // ****************************************************************
  // refresh errors from empty numbers or units already stopped are ignored
  assign err_set = (dup_mask | (refresh_err & used_mask & ~stop_ff)) & range_mask;

  // set wins over a restart completing in the same cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= (flags_ff & ~done_clr) | err_set; // RULE_04 RULE_10
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stop_ff <= '0;
    end else begin
      stop_ff <= (stop_ff & ~done_clr) | (err_set & ~dup_mask); // RULE_03
    end
  end

  assign unit_stop    = stop_ff | (halt_ff ? range_mask : 16'h0000);
  assign program_halt = halt_ff;
  assign special_unit_error_summary_bit = halt_ff | (|flags_ff); // RULE_01 RULE_03

  // ****************************************************************
  // refresh scan
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_ff <= '0;
    end else if (div_ff == 8'(REFRESH_DIV - 1)) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  assign tick = (div_ff == 8'(REFRESH_DIV - 1)) && (state_ff == ST_SCAN);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scan_word_ff <= '0;
      scan_unit_ff <= '0;
    end else if (tick) begin
      if (scan_word_ff == 4'(`SUE_WORDS_PER_UNIT - 1)) begin
        scan_word_ff <= '0;
        if (scan_unit_ff == (EXT_EN ? 4'hF : 4'(`SUE_PRI_UNITS - 1))) begin
          scan_unit_ff <= '0;
        end else begin
          scan_unit_ff <= scan_unit_ff + 4'h1;
        end
      end else begin
        scan_word_ff <= scan_word_ff + 4'h1;
      end
    end
  end

  // stopped or restarting units get no refresh traffic
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      refresh_ff <= '0;
    end else begin
      refresh_ff.valid     <= tick && used_mask[scan_unit_ff] && !stop_ff[scan_unit_ff]
                              && !busy_ff[scan_unit_ff] && !halt_ff; // RULE_03
      refresh_ff.unit      <= scan_unit_ff;
      refresh_ff.word_addr <= unit_base(scan_unit_ff) + 10'(scan_word_ff); // RULE_11
    end
  end

  assign refresh = refresh_ff;

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      restart_pri_ff <= `SUE_RST_WORD;
      restart_ext_ff <= `SUE_RST_WORD;
    end else if (bus_req.wr) begin
      if (bus_req.addr == `SUE_OFS_RESTART_PRI) begin
        restart_pri_ff <= bus_req.wdata & 16'h03FF;
      end
      if (bus_req.addr == `SUE_OFS_RESTART_EXT) begin
        restart_ext_ff <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_mask_ff <= `SUE_RST_IRQ_MASK;
    end else if (bus_req.wr && bus_req.addr == `SUE_OFS_IRQ_MASK) begin
      irq_mask_ff <= bus_req.wdata[2:0];
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  always_comb begin
    irq_event = '0;
    irq_event[`SUE_IRQ_DUP_BIT]     = |dup_mask;
    irq_event[`SUE_IRQ_REFRESH_BIT] = |(err_set & ~dup_mask);
    irq_event[`SUE_IRQ_RESTART_BIT] = |done_clr;
  end

  assign rd_stat = bus_req.rd && (bus_req.addr == `SUE_OFS_IRQ_STAT);

  // read clears, but an event in the same cycle survives
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (rd_stat ? 3'h0 : irq_stat_ff) | irq_event;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_comb begin
    nxt_rdata = '0;
    case (bus_req.addr)
      `SUE_OFS_STATUS: begin
        nxt_rdata[`SUE_STAT_HALT_BIT]    = halt_ff;
        nxt_rdata[`SUE_STAT_SUMMARY_BIT] = special_unit_error_summary_bit;
        nxt_rdata[`SUE_STAT_EXT_EN_BIT]  = EXT_EN;
      end
      `SUE_OFS_FLAGS_PRI:   nxt_rdata = flags_ff & 16'h03FF; // RULE_04
      `SUE_OFS_FLAGS_EXT:   nxt_rdata = EXT_EN ? flags_ff : 16'h0000; // RULE_05
      `SUE_OFS_RESTART_PRI: nxt_rdata = restart_pri_ff;
      `SUE_OFS_RESTART_EXT: nxt_rdata = restart_ext_ff;
      `SUE_OFS_IRQ_STAT:    nxt_rdata = {13'h0000, irq_stat_ff};
      `SUE_OFS_IRQ_MASK:    nxt_rdata = {13'h0000, irq_mask_ff};
      `SUE_OFS_DUP_MASK:    nxt_rdata = dup_seen_ff & range_mask; // RULE_02
      default:              nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_ff <= '0;
    end else if (bus_req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign bus_rdata = rdata_ff;
endmodule

// [hw/sue_toggle_det.sv]
`timescale 1ns/1ps

// off -> on -> off detector, one per bit
module sue_toggle_det #(
  parameter int W = 16
) (
  input  wire logic         clk_sys, // system clock
  input  wire logic         reset,   // async reset, active high
  input  wire logic [W-1:0] level,   // restart request levels
  output logic      [W-1:0] pulse    // one-cycle restart event
);

  logic [W-1:0] prev_ff;
  logic [W-1:0] seen_on_ff;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= level;
    end
  end

  // prev_ff resets to off, so a bit held on across reset release counts as
  // coming from off and fires a restart when it next goes off
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      seen_on_ff <= '0;
    end else begin
      seen_on_ff <= (seen_on_ff | (level & ~prev_ff)) & level;
    end
  end

  assign pulse = seen_on_ff & ~level; // RULE_06
endmodule

// [sim/special_unit_error_restart_test.sv]
`timescale 1ns/1ps
`include "sue_params.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end

module special_unit_error_restart_test;
  import sue_pkg::*;
  logic                clk_sys, reset, slow, rd_seen, program_halt, summary, irq;
  sue_bus_req_t        bus_req;
  sue_refresh_t        refresh;
  logic         [15:0] bus_rdata, rst_done, ref_err, unit_restart, unit_stop, bad;
  logic         [15:0] slot_present, e;
  sue_unit_no_t [15:0] slot_unit_no;
  logic         [15:0] exp_q[$];
  int                  fails, comparisons, seed, i;

  sue_supervisor #(.N_SLOTS(16), .EXT_EN(1'b1), .REFRESH_DIV(2)) uut (
    .clk_sys(clk_sys), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .slot_present(slot_present), .slot_unit_no(slot_unit_no), .refresh_err(ref_err),
    .restart_done(rst_done), .unit_restart(unit_restart), .unit_stop(unit_stop),
    .program_halt(program_halt), .special_unit_error_summary_bit(summary),
    .refresh(refresh), .irq(irq));
  sue_unit_model far (.clk_sys(clk_sys), .reset(reset), .unit_restart(unit_restart),
    .refresh(refresh), .bad(bad), .slow(slow), .restart_done(rst_done),
    .refresh_err(ref_err));

  always #25 clk_sys = ~clk_sys;

  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic w);
    @(posedge clk_sys);
    bus_req <= '{a, d, w, !w};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    exp_q.push_back(x);
    bus(a, 16'h0000, 1'b0);
  endtask

  task automatic restart(input logic [3:0] a, input logic [15:0] m);
    bus(a, 16'h0000, 1'b1);
    bus(a, m, 1'b1);
    bus(a, 16'h0000, 1'b1);
  endtask

  task automatic wait_stop(input int u, input logic v);
    int n;
    n = 0;
    while (unit_stop[u] !== v && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    if (unit_stop[u] !== v) begin
      fails++;
      give_verdict();
    end
  endtask

  // ****************
  // read data watcher
  // ****************
  always @(posedge clk_sys) begin
    rd_seen <= bus_req.rd;
    if (rd_seen === 1'b1) begin
      e = exp_q.pop_front();
      `CHK("bus_rdata", e, bus_rdata)
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 38;
    clk_sys = 0;
    reset = 1;
    slow = 0;
    bad = '0;
    bus_req = '0;
    slot_present = 16'h1008;
    // absent slots carry junk numbers that must not count as duplicates
    for (i = 0; i < 16; i++) slot_unit_no[i] = 4'($random(seed));
    slot_unit_no[3] = 4'h3;
    slot_unit_no[12] = 4'hC;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    i = 0;
    while (unit_restart === 16'h0000 && i < 8) begin
      @(negedge clk_sys);
      i++;
    end
    `CHK("power_up", 16'hFFFF, unit_restart)
    repeat (6) @(negedge clk_sys);
    rd(`SUE_OFS_IRQ_STAT, 16'h0004);
    rd(`SUE_OFS_STATUS, 16'h0004);
    bus(4'h8 | 4'($random(seed)), 16'($random(seed)), 1'b1);
    rd(4'hF, 16'h0000);
    bus(`SUE_OFS_IRQ_MASK, 16'h0002, 1'b1);
    bad <= 16'h0008;
    wait_stop(3, 1'b1);
    bad <= 16'h0000;
    repeat (2) @(negedge clk_sys);
    `CHK("irq", 1'b1, irq)
    `CHK("halt", 1'b0, program_halt)
    `CHK("summary", 1'b1, summary)
    rd(`SUE_OFS_FLAGS_PRI, 16'h0008);
    rd(`SUE_OFS_STATUS, 16'h0006);
    rd(`SUE_OFS_IRQ_STAT, 16'h0002);
    rd(`SUE_OFS_IRQ_STAT, 16'h0000);
    @(negedge clk_sys);
    `CHK("irq_clear", 1'b0, irq)
    bad <= 16'h1000;
    wait_stop(12, 1'b1);
    bad <= 16'h0000;
    rd(`SUE_OFS_FLAGS_EXT, 16'h1008);
    slow <= 1'b1;
    restart(`SUE_OFS_RESTART_PRI, 16'h0008);
    wait_stop(3, 1'b0);
    slow <= 1'b0;
    restart(`SUE_OFS_RESTART_EXT, 16'h1000);
    wait_stop(12, 1'b0);
    rd(`SUE_OFS_FLAGS_EXT, 16'h0000);
    bad <= 16'h0008;
    wait_stop(3, 1'b1);
    rd(`SUE_OFS_FLAGS_PRI, 16'h0008);
    bad <= 16'h0000;
    slot_unit_no[5] <= 4'hC;
    slot_present <= 16'h1028;
    wait_stop(0, 1'b1);
    `CHK("halt", 1'b1, program_halt)
    rd(`SUE_OFS_STATUS, 16'h0007);
    rd(`SUE_OFS_FLAGS_EXT, 16'h1008);
    rd(`SUE_OFS_DUP_MASK, 16'h1000);
    repeat (3) @(posedge clk_sys);
    give_verdict();
  end
endmodule

// [sim/sue_supervisor_props.sv]
`timescale 1ns/1ps

// ****************
// port checks
// ****************
module sue_supervisor_props #(
  parameter int REFRESH_DIV = 2,
  parameter bit EXT_EN      = 1'b1
) (
  input wire logic                  clk_sys,      // system clock
  input wire logic                  reset,        // async reset
  input wire sue_pkg::sue_bus_req_t bus_req,      // register request
  input wire logic           [15:0] bus_rdata,    // read data
  input wire logic           [15:0] refresh_err,  // refresh error
  input wire logic           [15:0] unit_restart, // restart pulses
  input wire logic           [15:0] unit_stop,    // unit stopped
  input wire logic                  program_halt, // program stopped
  input wire logic                  special_unit_error_summary_bit, // summary
  input wire sue_pkg::sue_refresh_t refresh       // refresh slot
);
  import sue_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_restart_single: assert property ((unit_restart & $past(unit_restart)) == 16'h0000)
    else $error("restart pulse too long");
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (bus_req.rd && bus_req.addr[3] |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_halt_sticky: assert property (program_halt |=> program_halt)
    else $error("halt dropped");
  a_halt_stops_all: assert property (
    program_halt |-> unit_stop == (EXT_EN ? 16'hFFFF : 16'h03FF) && special_unit_error_summary_bit)
    else $error("halt without full stop");
  // a stop without a refresh error is only allowed under a halt
  a_stop_cause: assert property (
    !program_halt |-> (unit_stop & ~$past(unit_stop) & ~$past(refresh_err)) == 16'h0000)
    else $error("unit stopped without cause");
  a_stop_summary: assert property (|unit_stop |-> special_unit_error_summary_bit)
    else $error("summary low while unit stopped");
  // with a divider of one every cycle is a legal slot
  a_valid_pulse: assert property (refresh.valid && REFRESH_DIV > 1 |=> !refresh.valid)
    else $error("refresh valid too long");
  a_word_pri: assert property (
    refresh.valid && refresh.unit < 4'hA |->
    (int'(refresh.word_addr) - 10 * int'(refresh.unit) - 100) inside {[0:9]})
    else $error("bad low word address");
  a_word_ext: assert property (
    refresh.valid && refresh.unit > 4'h9 |->
    (int'(refresh.word_addr) - 10 * int'(refresh.unit) - 300) inside {[0:9]})
    else $error("bad high word address");
  a_halt_no_scan: assert property (program_halt && $past(program_halt) |-> !refresh.valid)
    else $error("refresh while halted");

  c_power_up: cover property (unit_restart == 16'hFFFF);
  c_halt: cover property ($rose(program_halt));
  c_err_stop: cover property ($rose(unit_stop[3]));
endmodule

bind sue_supervisor sue_supervisor_props #(
  .REFRESH_DIV (REFRESH_DIV),
  .EXT_EN      (EXT_EN)
) u_props (
  .clk_sys (clk_sys), .reset (reset), .bus_req (bus_req), .bus_rdata (bus_rdata),
  .refresh_err (refresh_err), .unit_restart (unit_restart), .unit_stop (unit_stop),
  .program_halt (program_halt), .refresh (refresh),
  .special_unit_error_summary_bit (special_unit_error_summary_bit)
);

// [sim/sue_unit_model.sv]
`timescale 1ns/1ps

// ****************
// backplane units
// ****************
module sue_unit_model (
  input  wire logic                  clk_sys,      // system clock
  input  wire logic                  reset,        // async reset
  input  wire logic           [15:0] unit_restart, // restart pulses
  input  wire sue_pkg::sue_refresh_t refresh,      // refresh slot
  input  wire logic           [15:0] bad,          // units failing refresh
  input  wire logic                  slow,         // slow restart answer
  output logic                [15:0] restart_done, // restart finished
  output logic                [15:0] refresh_err   // refresh failed
);
  import sue_pkg::*;
  logic [15:0] pend_ff;
  logic [4:0]  cnt_ff;

  // one shared timer: later requests merge into the pending answer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pend_ff <= 16'h0000;
      cnt_ff <= 5'h00;
      restart_done <= 16'h0000;
    end else begin
      restart_done <= 16'h0000;
      if (|unit_restart) begin
        pend_ff <= pend_ff | unit_restart;
        cnt_ff <= slow ? 5'h1F : 5'h02;
      end else if (cnt_ff == 5'h01) begin
        restart_done <= pend_ff;
        pend_ff <= 16'h0000;
        cnt_ff <= 5'h00;
      end else if (cnt_ff != 5'h00) begin
        cnt_ff <= cnt_ff - 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      refresh_err <= 16'h0000;
    end else begin
      refresh_err <= (refresh.valid && bad[refresh.unit]) ? 16'h0001 << refresh.unit : 16'h0000;
    end
  end
endmodule
